// file: hdl/adc_seq_pkg.sv
/*
  Shared constants for the dual-slope converter sequencer and its controller end.
  Assumes a single 125 MHz clock and an analog processor that follows a 2-bit phase code.
*/
package adc_seq_pkg;

  // ==========================================================================
  // Clocking
  localparam int unsigned CLK_MHZ     = 125;   // Cycles per microsecond
  localparam int unsigned SYS_DIV     = 4;     // System clock = input clock / 4
  localparam logic [1:0]  DIV_LAST    = 2'h3;  // Last count of the divide-by-four

  // ==========================================================================
  // Integration times in microseconds, index = {b2,b1,b0}
  localparam logic [7:0][31:0] INT_TIME_US = {
    32'd300000, 32'd200000, 32'd166667, 32'd100000,
    32'd66667,  32'd50000,  32'd33333,  32'd16667};

  // Least time, so the tick count rounds up
  function automatic logic [31:0] us_to_ticks(input logic [31:0] us);
    logic [63:0] prod;
    prod = (64'(us) * 64'(CLK_MHZ) + 64'(SYS_DIV) - 64'h1) / 64'(SYS_DIV);
    return prod[31:0];
  endfunction

  function automatic logic [7:0][31:0] int_ticks_table();
    logic [7:0][31:0] t;
    for (int i = 0; i < 8; i++) begin
      t[i] = us_to_ticks(INT_TIME_US[i]);
    end
    return t;
  endfunction

  localparam logic [7:0][31:0] INT_TICKS_DEFAULT = int_ticks_table();

  // ==========================================================================
  // Sequencer timing, in system-clock ticks
  localparam logic [31:0] INIT_TICKS = 32'h0000_0010;  // Power-on clear
  localparam logic [31:0] AZ_TICKS   = 32'h0000_0100;  // Auto zero, covers 24 bits
  localparam logic [31:0] IZ_TICKS   = 32'h0000_0040;  // Integrator zero

  // ==========================================================================
  // Result format and phase codes to the analog processor
  localparam int unsigned RESULT_W  = 24;
  localparam int unsigned MAG_W     = 23;
  localparam logic [4:0]  RESULT_BITS = 5'h18;
  localparam logic [1:0]  PH_AUTO_ZERO   = 2'h0;
  localparam logic [1:0]  PH_INTEGRATE   = 2'h1;
  localparam logic [1:0]  PH_DEINTEGRATE = 2'h2;
  localparam logic [1:0]  PH_INT_ZERO    = 2'h3;

  // ==========================================================================
  // Controller registers on AHB-Lite
  localparam int unsigned FIFO_DEPTH   = 8;
  localparam logic [31:0] CTRL_OFFSET   = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;
  localparam logic [31:0] DATA_OFFSET   = 32'h0000_0008;
  localparam int unsigned CTRL_SELECT   = 0;
  localparam int unsigned CTRL_SLEEP    = 1;
  localparam int unsigned CTRL_ISEL_LSB = 2;
  localparam int unsigned ST_NOT_EMPTY  = 0;
  localparam int unsigned ST_FULL       = 1;
  localparam int unsigned ST_OVERFLOW   = 2;
  localparam int unsigned ST_HOLD       = 3;
  localparam logic [2:0]  ISEL_RESET    = 3'h4;  // 100 ms

endpackage

// file: hdl/adc_link_if.sv
/*
  Pins between the sequencer and its controller.
  Assumes the board pulls the ready line high and the data lines low when nobody drives them.
*/
`timescale 1ns/10ps
`default_nettype none

interface adc_link_if;
  // Device-driven pins with their enables
  logic ready_n;
  logic ready_n_oe;
  logic sdata;
  logic sdata_oe;
  logic sclk;
  logic sclk_oe;
  // Controller-driven pins
  logic select_n;
  logic sleep_request;
  logic int_time_sel_b2;
  logic int_time_sel_b1;
  logic int_time_sel_b0;
  // Resolved wire levels
  logic ready_n_line;
  logic sdata_line;
  logic sclk_line;

  // ==========================================================================
  // Wire levels; undriven lines fall to their pull
  assign ready_n_line = ready_n_oe ? ready_n : 1'b1;
  assign sdata_line   = sdata_oe ? sdata : 1'b0;
  assign sclk_line    = sclk_oe ? sclk : 1'b0;

  modport device (
    output ready_n, ready_n_oe, sdata, sdata_oe, sclk, sclk_oe,
    input  select_n, sleep_request, int_time_sel_b2, int_time_sel_b1, int_time_sel_b0
  );
  modport host (
    input  ready_n_line, sdata_line, sclk_line,
    output select_n, sleep_request, int_time_sel_b2, int_time_sel_b1, int_time_sel_b0
  );
endinterface

`default_nettype wire

// file: hdl/adc_sequencer.sv
/*
  Dual-slope converter sequencer: runs the analog processor through its phases,
  times integration, counts deintegration and shifts each result out serially.
  Assumes an analog processor that takes a 2-bit phase code and a sleep level and
  returns a comparator level; all pins from outside are asynchronous.
*/
`timescale 1ns/10ps
`default_nettype none

module adc_sequencer
  import adc_seq_pkg::*;
#(
  parameter logic [7:0][31:0] INT_TICKS = INT_TICKS_DEFAULT
) (
  // Clock and reset
  input  wire logic  i_clk,
  input  wire logic  i_rst,
  // Analog processor
  input  wire logic  i_comparator,
  output logic [1:0] o_phase,
  output logic       o_proc_sleep,
  // Link to the controller
  adc_link_if.device link
);

  typedef enum logic [2:0] {
    ST_INIT, ST_SLEEP, ST_AUTO_ZERO, ST_INTEGRATE, ST_DEINTEGRATE, ST_INT_ZERO
  } seq_state_t;

  typedef struct packed {
    seq_state_t  state;
    logic [1:0]  div;
    logic [31:0] cnt;
    logic [31:0] int_len;
    logic        comp_s1;
    logic        comp_s2;
    logic        comp_prev;
    logic        sleep_s1;
    logic        sleep_s2;
    logic        sel_n_s1;
    logic        sel_n_s2;
    logic [2:0]  isel_s1;
    logic [2:0]  isel_s2;
    logic        sign;
    logic [22:0] mag;
    logic        have_result;
    logic [23:0] shreg;
    logic [4:0]  bits_left;
    logic        ready_n;
    logic        sdata;
    logic        sclk;
    logic        proc_sleep;
    logic [1:0]  phase;
  } seq_regs_t;

  seq_regs_t r;
  seq_regs_t next_r;
  logic      tick;
  logic      comp_fall;

  // ==========================================================================
  // Next state
  always_comb begin
    next_r = r;
    // Every asynchronous pin passes two flops before use
    next_r.comp_s1   = i_comparator;
    next_r.comp_s2   = r.comp_s1;
    next_r.comp_prev = r.comp_s2;
    next_r.sleep_s1  = link.sleep_request;
    next_r.sleep_s2  = r.sleep_s1;
    next_r.sel_n_s1  = link.select_n;
    next_r.sel_n_s2  = r.sel_n_s1;
    next_r.isel_s1   = {link.int_time_sel_b2, link.int_time_sel_b1, link.int_time_sel_b0};
    next_r.isel_s2   = r.isel_s1;
    next_r.div       = r.div + 2'h1;
    tick             = (r.div == DIV_LAST);
    // Edge is watched every clock so a short dip is not missed between ticks
    comp_fall        = r.comp_prev & ~r.comp_s2;

    if (r.state != ST_INIT && r.state != ST_SLEEP && r.sleep_s2) begin
      // Sleep aborts any conversion; the half result is not kept
      next_r.state       = ST_SLEEP;
      next_r.proc_sleep  = 1'b1;
      next_r.ready_n     = 1'b1;
      next_r.sclk        = 1'b0;
      next_r.have_result = 1'b0;
    end else begin
      case (r.state)
        ST_INIT: begin
          // Counters and result were cleared by reset; wait, then look at sleep
          if (tick) begin
            next_r.cnt = r.cnt + 32'h1;
            if (r.cnt == INIT_TICKS - 32'h1) begin
              next_r.cnt   = 32'h0;
              next_r.state = r.sleep_s2 ? ST_SLEEP : ST_AUTO_ZERO;
              next_r.proc_sleep = r.sleep_s2;
              next_r.phase = PH_AUTO_ZERO;
            end
          end
        end
        ST_SLEEP: begin
          if (!r.sleep_s2) begin
            next_r.state      = ST_AUTO_ZERO;
            next_r.proc_sleep = 1'b0;
            next_r.phase      = PH_AUTO_ZERO;
            next_r.cnt        = 32'h0;
          end
        end
        ST_AUTO_ZERO: begin
          if (tick) begin
            next_r.cnt = r.cnt + 32'h1;
            if (r.cnt == 32'h0 && r.have_result) begin
              // Load sign first, then magnitude MSB down
              next_r.shreg     = {r.sign, r.mag};
              next_r.bits_left = RESULT_BITS;
              next_r.ready_n   = 1'b0;
            end else if (r.bits_left != 5'h0) begin
              // Four ticks per bit: data set with clock low, clock high mid-bit
              case (r.cnt[1:0])
                2'h1: begin
                  next_r.sdata = r.shreg[RESULT_W-1];
                  next_r.sclk  = 1'b0;
                end
                2'h2: next_r.sclk = 1'b1;
                2'h3: begin
                  next_r.shreg     = {r.shreg[RESULT_W-2:0], 1'b0};
                  next_r.bits_left = r.bits_left - 5'h1;
                end
                default: next_r.sclk = 1'b0;
              endcase
            end else begin
              next_r.sclk = 1'b0;
            end
            if (r.cnt == AZ_TICKS - 32'h1) begin
              next_r.state       = ST_INTEGRATE;
              next_r.phase       = PH_INTEGRATE;
              next_r.cnt         = 32'h0;
              next_r.ready_n     = 1'b1;
              next_r.sclk        = 1'b0;
              next_r.bits_left   = 5'h0;
              next_r.have_result = 1'b0;
              next_r.int_len     = INT_TICKS[r.isel_s2];
            end
          end
        end
        ST_INTEGRATE: begin
          if (tick) begin
            next_r.cnt = r.cnt + 32'h1;
            if (r.cnt == r.int_len - 32'h1) begin
              // Comparator high at the end of integration marks a negative input
              next_r.sign  = r.comp_s2;
              next_r.state = ST_DEINTEGRATE;
              next_r.phase = PH_DEINTEGRATE;
              next_r.cnt   = 32'h0;
            end
          end
        end
        ST_DEINTEGRATE: begin
          if (comp_fall) begin
            // Magnitude saturates at 23 bits
            next_r.mag = (r.cnt[31:MAG_W] != '0) ? '1 : r.cnt[MAG_W-1:0];
            next_r.have_result = 1'b1;
            next_r.state = ST_INT_ZERO;
            next_r.phase = PH_INT_ZERO;
            next_r.cnt   = 32'h0;
          end else if (tick) begin
            next_r.cnt = r.cnt + 32'h1;
            // No crossing within twice the integration time is an overrange
            if (r.cnt == {r.int_len[30:0], 1'b0}) begin
              next_r.mag         = '1;
              next_r.have_result = 1'b1;
              next_r.state       = ST_INT_ZERO;
              next_r.phase       = PH_INT_ZERO;
              next_r.cnt         = 32'h0;
            end
          end
        end
        ST_INT_ZERO: begin
          if (tick) begin
            next_r.cnt = r.cnt + 32'h1;
            if (r.cnt == IZ_TICKS - 32'h1) begin
              next_r.state = ST_AUTO_ZERO;
              next_r.phase = PH_AUTO_ZERO;
              next_r.cnt   = 32'h0;
            end
          end
        end
        default: begin
          next_r.state = ST_INIT;
          next_r.cnt   = 32'h0;
        end
      endcase
    end
  end

  // ==========================================================================
  // State register; reset is the power-on clear
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r         <= '0;
      r.state   <= ST_INIT;
      r.ready_n <= 1'b1;
      r.sel_n_s1 <= 1'b1;
      r.sel_n_s2 <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================================
  // Outputs; pins float while deselected
  assign o_phase         = r.phase;
  assign o_proc_sleep    = r.proc_sleep;
  assign link.ready_n    = r.ready_n;
  assign link.sdata      = r.sdata;
  assign link.sclk       = r.sclk;
  assign link.ready_n_oe = ~r.sel_n_s2;
  assign link.sdata_oe   = ~r.sel_n_s2;
  assign link.sclk_oe    = ~r.sel_n_s2;

endmodule // adc_sequencer

`default_nettype wire

// file: hdl/adc_controller.sv
/*
  Controller end: AHB-Lite register slave that drives the select, sleep and
  integration-time pins, receives serial results and queues them in a FIFO.
  Assumes one AHB-Lite master, word transfers only, and a device on adc_link_if.
*/
// The address map and the AHB-Lite register port were decided locally.
`timescale 1ns/10ps
`default_nettype none

module sample_fifo #(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // Fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Drain side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 count;
  } fifo_regs_t;

  fifo_regs_t r;
  fifo_regs_t next_r;
  logic       push;
  logic       pop;

  // ==========================================================================
  // Pointers wrap at DEPTH so non-power-of-two depths also work
  always_comb begin
    next_r = r;
    push   = i_in_valid & o_in_ready;
    pop    = o_out_valid & i_out_ready;
    if (push) begin
      next_r.mem[r.wr] = i_in_data;
      next_r.wr = (r.wr == AW'(DEPTH - 1)) ? '0 : r.wr + 1'b1;
    end
    if (pop) begin
      next_r.rd = (r.rd == AW'(DEPTH - 1)) ? '0 : r.rd + 1'b1;
    end
    next_r.count = r.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign o_in_ready  = (r.count != (AW+1)'(DEPTH));
  assign o_out_valid = (r.count != '0);
  assign o_out_data  = r.mem[r.rd];
endmodule // sample_fifo

module adc_controller
  import adc_seq_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Link to the sequencer
  adc_link_if.host         link
);

  typedef struct packed {
    logic        sel;
    logic        sleep;
    logic [2:0]  isel;
    logic        wr_pend;
    logic [31:0] wr_addr;
    logic [31:0] rdata;
    logic        rdy_s1;
    logic        rdy_s2;
    logic        rdy_prev;
    logic        clk_s1;
    logic        clk_s2;
    logic        clk_prev;
    logic        dat_s1;
    logic        dat_s2;
    logic [23:0] rx_sh;
    logic [4:0]  rx_cnt;
    logic        hold_v;
    logic [23:0] hold;
    logic        overflow;
  } ctl_regs_t;

  ctl_regs_t   r;
  ctl_regs_t   next_r;
  logic        addr_phase;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [23:0] fifo_out_data;
  logic        fifo_pop;
  logic        word_done;
  logic        push;

  sample_fifo #(
    .WIDTH (RESULT_W),
    .DEPTH (FIFO_DEPTH)
  ) sample_fifo_i (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_in_valid  (r.hold_v),
    .i_in_data   (r.hold),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (fifo_out_valid),
    .o_out_data  (fifo_out_data),
    .i_out_ready (fifo_pop)
  );

  // ==========================================================================
  // Bus decode and receiver
  assign addr_phase = hsel & htrans[1] & hready;
  assign fifo_pop   = addr_phase & ~hwrite & (haddr == DATA_OFFSET) & fifo_out_valid;

  always_comb begin
    next_r = r;
    // Link pins come from another device and are synchronised first
    next_r.rdy_s1   = link.ready_n_line;
    next_r.rdy_s2   = r.rdy_s1;
    next_r.rdy_prev = r.rdy_s2;
    next_r.clk_s1   = link.sclk_line;
    next_r.clk_s2   = r.clk_s1;
    next_r.clk_prev = r.clk_s2;
    next_r.dat_s1   = link.sdata_line;
    next_r.dat_s2   = r.dat_s1;

    // Address phase: latch writes, answer reads from flops in the data phase
    next_r.wr_pend = addr_phase & hwrite;
    if (addr_phase) begin
      next_r.wr_addr = haddr;
    end
    if (addr_phase && !hwrite) begin
      case (haddr)
        CTRL_OFFSET:   next_r.rdata = {27'h0, r.isel, r.sleep, r.sel};
        STATUS_OFFSET: next_r.rdata = {28'h0, r.hold_v, r.overflow,
                                       ~fifo_in_ready, fifo_out_valid};
        DATA_OFFSET:   next_r.rdata = fifo_out_valid ? {8'h0, fifo_out_data} : 32'h0;
        default:       next_r.rdata = 32'h0;
      endcase
    end

    // Data phase write; select only moves on software's order
    if (r.wr_pend) begin
      case (r.wr_addr)
        CTRL_OFFSET: begin
          next_r.sel   = hwdata[CTRL_SELECT];
          next_r.sleep = hwdata[CTRL_SLEEP];
          next_r.isel  = hwdata[CTRL_ISEL_LSB+2:CTRL_ISEL_LSB];
        end
        STATUS_OFFSET: begin
          if (hwdata[ST_OVERFLOW]) begin
            next_r.overflow = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Shift in on each rising serial clock while ready is low, sign first
    if (!r.rdy_s2 && r.clk_s2 && !r.clk_prev) begin
      next_r.rx_sh  = {r.rx_sh[RESULT_W-2:0], r.dat_s2};
      next_r.rx_cnt = (r.rx_cnt == RESULT_BITS) ? r.rx_cnt : r.rx_cnt + 5'h1;
    end
    word_done = r.rdy_s2 & ~r.rdy_prev;
    push      = r.hold_v & fifo_in_ready;
    if (push) begin
      next_r.hold_v = 1'b0;
    end
    if (word_done) begin
      next_r.rx_cnt = 5'h0;
      // A short word is dropped; a full word waits in hold while the FIFO is full
      if (r.rx_cnt == RESULT_BITS) begin
        if (r.hold_v && !push) begin
          next_r.overflow = 1'b1;
        end else begin
          next_r.hold_v = 1'b1;
          next_r.hold   = r.rx_sh;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r          <= '0;
      r.isel     <= ISEL_RESET;
      r.rdy_s1   <= 1'b1;
      r.rdy_s2   <= 1'b1;
      r.rdy_prev <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================================
  // Outputs
  assign hreadyout            = 1'b1;
  assign hresp                = 1'b0;
  assign hrdata               = r.rdata;
  assign link.select_n        = ~r.sel;
  assign link.sleep_request   = r.sleep;
  assign link.int_time_sel_b2 = r.isel[2];
  assign link.int_time_sel_b1 = r.isel[1];
  assign link.int_time_sel_b0 = r.isel[0];

endmodule // adc_controller

`default_nettype wire

// file: testbench/adc_link_checker.sv
/*
  Assertions on the pins between the sequencer and its controller.
  Assumes the testbench feeds it the link signals by name, one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none

module adc_link_checker (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Device-driven pins
  input wire logic ready_n,
  input wire logic ready_n_oe,
  input wire logic sdata,
  input wire logic sdata_oe,
  input wire logic sclk,
  input wire logic sclk_oe,
  // Controller-driven pins
  input wire logic select_n,
  input wire logic sleep_request
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // ==========================================================================
  // Shift pulses seen in one result window
  logic       sclk_q;
  logic [5:0] n_bits;

  // Cleared whenever the window is closed, so an abort cannot leak counts
  always_ff @(posedge i_clk) begin
    sclk_q <= sclk;
    if (i_rst || ready_n)
      n_bits <= 6'h00;
    else if (sclk && !sclk_q)
      n_bits <= n_bits + 6'h01;
  end

  // ==========================================================================
  // Pin properties
  a_oe_together: assert property (ready_n_oe == sdata_oe && sclk_oe == sdata_oe)
    else $error("link enables disagree");
  a_deselect_float: assert property ($rose(select_n) |-> ##[1:4] !ready_n_oe)
    else $error("pins still driven after deselect");
  a_select_drive: assert property ($fell(select_n) |-> ##[1:4] ready_n_oe)
    else $error("pins not driven after select");
  a_sleep_ready: assert property (sleep_request [*5] |-> ready_n)
    else $error("ready low while asleep");
  a_clk_in_window: assert property ($rose(sclk) |-> !ready_n)
    else $error("shift pulse outside ready window");
  a_data_steady: assert property ($rose(sclk) |-> $stable(sdata))
    else $error("data moved at shift edge");
  a_sclk_high_len: assert property (disable iff (i_rst || sleep_request)
    $rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("shift pulse not two ticks long");
  a_word_bits: assert property (disable iff (i_rst || sleep_request)
    $rose(ready_n) |-> n_bits == 6'h18)
    else $error("result window without 24 bits");
endmodule // adc_link_checker

`default_nettype wire

// file: testbench/dual_slope_adc_sequencer_tb.sv
/*
  Testbench: sequencer and controller joined by their link, driven over AHB-Lite.
  Assumes the package constants; a bench model captures words off the wire.
*/
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

module dual_slope_adc_sequencer_tb
  import adc_seq_pkg::*;
;
  logic        i_clk, i_rst, comp, hsel, hwrite, hreadyout, hresp, psleep;
  logic        pslp, sgn, sgn_last, rdy_q, sclk_q;
  logic [1:0]  htrans, phase, pph;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [23:0] sh;
  logic [23:0] q[$];
  int          failures, n_checks, seed, nb, dcnt, dlen, n, dl_last;

  // Short integration counts keep the run brief; all eight differ
  function automatic logic [7:0][31:0] tk_f();
    logic [7:0][31:0] t;
    for (int i = 0; i < 8; i++) t[i] = 32'(20 + 4 * i);
    return t;
  endfunction
  localparam logic [7:0][31:0] TK = tk_f();

  // ==========================================================================
  // Both ends and the checker
  adc_link_if lk ();
  adc_sequencer #(.INT_TICKS(TK)) adc_sequencer_i (.i_clk(i_clk), .i_rst(i_rst),
    .i_comparator(comp), .o_phase(phase), .o_proc_sleep(psleep), .link(lk));
  adc_controller adc_controller_i (.i_clk(i_clk), .i_rst(i_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(lk));
  adc_link_checker adc_link_checker_i (.i_clk(i_clk), .i_rst(i_rst),
    .ready_n(lk.ready_n), .ready_n_oe(lk.ready_n_oe), .sdata(lk.sdata),
    .sdata_oe(lk.sdata_oe), .sclk(lk.sclk), .sclk_oe(lk.sclk_oe),
    .select_n(lk.select_n), .sleep_request(lk.sleep_request));

  // 125 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // ==========================================================================
  // Analog stand-in and wire model; the comparator falls a random time into deintegrate
  always @(posedge i_clk) begin
    pph <= phase;
    pslp <= psleep;
    rdy_q <= lk.ready_n_line;
    sclk_q <= lk.sclk_line;
    if (!i_rst && !psleep && !pslp && phase !== pph)
      `CHK(phase, pph + 2'h1)
    if (pph == PH_DEINTEGRATE && phase == PH_INT_ZERO && !psleep)
      `CHK(dcnt > dlen && dcnt <= dlen + 12, 1'b1)
    if (phase == PH_INTEGRATE) begin
      comp <= sgn;
      dcnt <= 0;
    end else if (phase == PH_DEINTEGRATE) begin
      dcnt <= dcnt + 1;
      comp <= (dcnt < dlen);
      sgn_last <= sgn;
      dl_last <= dlen;
    end else begin
      comp <= 1'b0;
      sgn <= 1'($random(seed));
      dlen <= 8 + ($unsigned($random(seed)) % 64);
    end
    if (lk.sclk_line && !sclk_q && !lk.ready_n_line) begin
      sh <= {sh[22:0], lk.sdata_line};
      nb <= nb + 1;
    end
    if (!lk.ready_n_line && rdy_q) begin
      `CHK(phase, PH_AUTO_ZERO)
      nb <= 0;
    end
    if (lk.ready_n_line && !rdy_q && nb == 24) begin
      `CHK(sh[23], sgn_last)
      // Crossing seen three clocks late, counted in whole ticks
      `CHK(sh[22:0], 23'((dl_last + 3) / 4))
      if (q.size() < FIFO_DEPTH + 1) q.push_back(sh);
    end
  end

  // ==========================================================================
  // Bus tasks; every wait is bounded
  task automatic close_out();
    $display("Checks %0d, failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic rdy_wait();
    int k;
    k = 0;
    do begin @(posedge i_clk); k++; end while (hreadyout !== 1'b1 && k < 100);
    if (k >= 100) begin failures++; close_out(); end
  endtask

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    rdy_wait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy_wait();
    rd = hrdata;
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0000_0000);
    `CHK(rd, e)
  endtask

  task automatic wait_ph(input logic [1:0] p);
    n = 0;
    while (phase !== p && n < 20000) begin @(posedge i_clk); n++; end
    if (n >= 20000) begin failures++; close_out(); end
  endtask

  // Every captured word must come back in order, then the queue reads empty
  task automatic drain();
    logic [31:0] e;
    while (q.size() > 0) begin
      e = {8'h00, q.pop_front()};
      ahb(1'b0, DATA_OFFSET, 32'h0000_0000);
      `CHK(rd, e)
    end
    rdchk(DATA_OFFSET, 32'h0000_0000);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    seed = 32'h0000_e230;
    {i_rst, comp, hsel, hwrite, sgn} = 5'h10;
    {haddr, hwdata, htrans, hsize, nb, dlen} = '0;
    hsize = 3'h2;
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    rdchk(CTRL_OFFSET, 32'h0000_0010);
    rdchk(STATUS_OFFSET, 32'h0000_0000);
    ahb(1'b1, 32'h0000_0020, 32'hFFFF_FFFF);
    rdchk(32'h0000_0020, 32'h0000_0000);
    `CHK(lk.ready_n_oe, 1'b0)
    // Every integration time, measured in clocks
    for (int i = 0; i < 8; i++) begin
      ahb(1'b1, CTRL_OFFSET, 32'(i * 4 + 1));
      wait_ph(PH_INT_ZERO);
      wait_ph(PH_AUTO_ZERO);
      wait_ph(PH_INTEGRATE);
      wait_ph(PH_DEINTEGRATE);
      `CHK(32'(n), 32'(SYS_DIV) * TK[i])
      drain();
    end
    // Fill until the controller refuses, clear overflow, drain
    repeat (10) begin
      wait_ph(PH_INT_ZERO);
      wait_ph(PH_AUTO_ZERO);
    end
    wait_ph(PH_INTEGRATE);
    // The last word needs the ready rise to pass the synchroniser first
    repeat (4) @(posedge i_clk);
    rdchk(STATUS_OFFSET, 32'h0000_000F);
    ahb(1'b1, STATUS_OFFSET, 32'h0000_0004);
    rdchk(STATUS_OFFSET, 32'h0000_000B);
    drain();
    // Sleep powers the processor down and stops results
    ahb(1'b1, CTRL_OFFSET, 32'h0000_0013);
    repeat (20) @(posedge i_clk);
    `CHK(psleep, 1'b1)
    repeat (2000) @(posedge i_clk);
    `CHK({lk.ready_n_line, 32'(q.size())}, 33'h1_0000_0000)
    ahb(1'b1, CTRL_OFFSET, 32'h0000_0011);
    // Phase code is frozen while asleep, so wait for the restart first
    wait_ph(PH_AUTO_ZERO);
    wait_ph(PH_INTEGRATE);
    `CHK(psleep, 1'b0)
    // Deselect floats all three device pins
    ahb(1'b1, CTRL_OFFSET, 32'h0000_0010);
    repeat (8) @(posedge i_clk);
    `CHK({lk.ready_n_oe, lk.sdata_oe, lk.sclk_oe}, 3'h0)
    close_out();
  end
endmodule // dual_slope_adc_sequencer_tb

`default_nettype wire
